// [hw/adc_ctrl_pkg.sv]
/*
 * Shared constants and carrier types for the converter control block.
 * Assumes a 32-bit AXI4-Lite register bus and a converter core on the same clock.
 */
`default_nettype none
package adc_ctrl_pkg;
    // Register indices; the byte address is four times the index.
    localparam logic [5:0] IDX_CHANNEL_CONTROL = 6'h00; // Start bit and input kind.
    localparam logic [5:0] IDX_CLOCK_DIVIDER = 6'h04; // Prescaler code.
    localparam logic [5:0] IDX_BYTE_LATCH = 6'h05; // Byte latch for 16-bit pairs.
    localparam logic [5:0] IDX_COMPLETION_FLAGS = 6'h06; // Write-one-to-clear flag.
    localparam logic [5:0] IDX_SAMPLE_LENGTH = 6'h08; // Sample length value.
    localparam logic [5:0] IDX_TRIM_LOW = 6'h0C; // Trim bits 7:0.
    localparam logic [5:0] IDX_TRIM_HIGH = 6'h0D; // Trim bits 11:8.
    localparam logic [5:0] IDX_RESULT_LOW = 6'h10; // Formatted result, low byte.
    localparam logic [5:0] IDX_RESULT_HIGH = 6'h11; // Formatted result, high byte.
    localparam logic [5:0] IDX_THRESHOLD_LOW = 6'h18; // Compare value low byte.
    localparam logic [5:0] IDX_THRESHOLD_HIGH = 6'h19; // Compare value high byte.
    localparam logic [5:0] IDX_MAIN_CONTROL_A = 6'h20; // Start bit alias.
    localparam logic [5:0] IDX_MAIN_CONTROL_B = 6'h21; // Format, signedness, compare.
    // Field positions.
    localparam int START_BIT = 7; // Start bit in channel_control.
    localparam int ALIAS_START_BIT = 2; // Start bit in main_control_a.
    localparam int DONE_BIT = 0; // Flag bit in completion_flags.
    localparam int CMP_MODE_BIT = 0; // Compare mode in main_control_b.
    localparam int FMT_LSB = 1; // Format field low bit in main_control_b.
    localparam int SIGNED_BIT = 4; // Signedness select in main_control_b.
    // Result format codes.
    typedef enum logic [1:0] {
        FMT_RIGHT12 = 2'b00,
        FMT_RESERVED = 2'b01,
        FMT_RIGHT8 = 2'b10,
        FMT_LEFT12 = 2'b11
    } result_format_e;
    // Converter sequence states, Gray coded along idle, sample, convert.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONVERT = 2'b11
    } conv_state_e;
    // AXI responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Reset values.
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    // Commands to the converter core.
    typedef struct packed {
        logic conv_clk; // Prescaled converter clock.
        logic sampling; // High during the input sampling phase.
        logic convert_go; // One-cycle pulse that ends sampling.
        logic [11:0] trim; // Calibration trim applied to conversions.
    } core_cmd_s;
    // Answer from the converter core.
    typedef struct packed {
        logic done; // One-cycle pulse, conversion finished.
        logic [11:0] raw; // Raw result, valid with done.
    } core_ret_s;
endpackage
`default_nettype wire

// [hw/adc_control_result_regs.sv]
/*
 * Register and sequencing logic of a single-channel converter: prescaler,
 * sample timing, trim store, result formatting, compare and completion flag.
 * Assumes an AXI4-Lite master on aclk and a converter core on aclk whose
 * done pulse and raw result arrive synchronously.
 */
// Local design decision: the AXI4-Lite register port.
`default_nettype none
module adc_control_result_regs
    import adc_ctrl_pkg::*;
(
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read.
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Converter core.
    output core_cmd_s core_cmd,
    input wire core_ret_s core_ret,
    // Interrupt controller executes this channel's vector.
    input wire logic vector_taken
);
    // Prescaler half period in peripheral clocks for a divider code.
    function automatic logic [8:0] half_period(input logic [2:0] code);
        half_period = 9'h002 << code;
    endfunction

    // Places a raw result into the 16-bit result pair.
    function automatic logic [15:0] format_result(input logic [11:0] raw,
            input result_format_e fmt, input logic sgn, input logic diff);
        unique case (fmt)
            FMT_LEFT12: format_result = {raw, 4'h0};
            FMT_RIGHT8: format_result = {{8{sgn & raw[7]}}, raw[7:0]};
            default: format_result = {{4{diff & raw[11]}}, raw};
        endcase
    endfunction

    // Registers.
    logic start_q; // Pending start request.
    logic [1:0] input_kind_q; // Input kind field of channel_control.
    logic [2:0] divider_code_q; // Prescaler code.
    logic channel_done_flag_q; // Completion flag.
    logic [7:0] byte_latch_q; // Byte latch.
    logic [5:0] sample_length_value_q; // Sample length value.
    logic [11:0] trim_q; // Calibration trim.
    logic [15:0] conversion_result_q; // Formatted result pair.
    logic [15:0] threshold_value_q; // Compare threshold.
    logic cmp_mode_q; // Compare mode select.
    result_format_e fmt_q; // Result format select.
    logic signedness_select_q; // Signed conversion select.
    // Sequencer.
    conv_state_e state_q;
    logic [8:0] div_cnt_q; // Peripheral clocks within a half period.
    logic conv_clk_q; // Prescaled clock level.
    logic [5:0] half_cnt_q; // Half periods spent sampling.
    logic half_tick; // Last cycle of a half period.
    logic done_event; // Flag-setting conversion end.
    logic cmp_hit; // Result beyond threshold.
    logic [15:0] new_result; // Formatted result of the finishing conversion.
    // Bus.
    logic aw_held_q, w_held_q; // Address or data taken, waiting for the other.
    logic [5:0] wr_idx_q; // Held write index.
    logic [7:0] wr_byte_q; // Held write byte.
    logic wr_lane_q; // Byte lane 0 enabled.
    logic wr_fire; // Write performed this cycle.
    logic [5:0] wr_idx; // Index of the write performed.
    logic [7:0] wr_byte; // Byte of the write performed.
    logic wr_en; // Write with lane 0 enabled.
    logic rd_fire; // Read address taken this cycle.
    logic [5:0] rd_idx; // Index of that read.
    logic [7:0] rd_byte; // Read value.
    logic rd_ok; // Read index is mapped.
    logic wr_ok; // Write index is mapped.

    // Accept address and data in either order; one write is under way at a time.
    assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready = !w_held_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign rd_idx = s_axi_araddr[7:2];

    // Holds address and data until both have arrived.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            wr_idx_q <= 6'h00;
            wr_byte_q <= BYTE_ZERO;
            wr_lane_q <= 1'b0;
        end else if (wr_fire) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                wr_idx_q <= s_axi_awaddr[7:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wr_byte_q <= s_axi_wdata[7:0];
                wr_lane_q <= s_axi_wstrb[0];
            end
        end
    end

    // The write happens in the cycle both halves are present.
    always_comb begin
        wr_fire = (aw_held_q || (s_axi_awvalid && s_axi_awready))
            && (w_held_q || (s_axi_wvalid && s_axi_wready));
        wr_idx = aw_held_q ? wr_idx_q : s_axi_awaddr[7:2];
        wr_byte = w_held_q ? wr_byte_q : s_axi_wdata[7:0];
        wr_en = wr_fire && (w_held_q ? wr_lane_q : s_axi_wstrb[0]);
    end

    // Decodes which indices exist.
    function automatic logic mapped(input logic [5:0] idx);
        unique case (idx)
            IDX_CHANNEL_CONTROL, IDX_CLOCK_DIVIDER, IDX_BYTE_LATCH,
            IDX_COMPLETION_FLAGS, IDX_SAMPLE_LENGTH, IDX_TRIM_LOW, IDX_TRIM_HIGH,
            IDX_RESULT_LOW, IDX_RESULT_HIGH, IDX_THRESHOLD_LOW, IDX_THRESHOLD_HIGH,
            IDX_MAIN_CONTROL_A, IDX_MAIN_CONTROL_B: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    endfunction
    assign wr_ok = mapped(wr_idx);
    assign rd_ok = mapped(rd_idx);

    // Write response, one cycle after the write at the earliest.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read multiplexer; high bytes of 16-bit pairs come from the byte latch.
    always_comb begin
        rd_byte = BYTE_ZERO;
        unique case (rd_idx)
            IDX_CHANNEL_CONTROL: rd_byte = {start_q, 5'h00, input_kind_q};
            IDX_CLOCK_DIVIDER: rd_byte = {5'h00, divider_code_q};
            IDX_BYTE_LATCH: rd_byte = byte_latch_q;
            IDX_COMPLETION_FLAGS: rd_byte = {7'h00, channel_done_flag_q};
            IDX_SAMPLE_LENGTH: rd_byte = {2'h0, sample_length_value_q};
            IDX_TRIM_LOW: rd_byte = trim_q[7:0];
            IDX_TRIM_HIGH: rd_byte = {4'h0, trim_q[11:8]};
            IDX_RESULT_LOW: rd_byte = conversion_result_q[7:0];
            IDX_RESULT_HIGH, IDX_THRESHOLD_HIGH: rd_byte = byte_latch_q;
            IDX_THRESHOLD_LOW: rd_byte = threshold_value_q[7:0];
            IDX_MAIN_CONTROL_A: rd_byte = {5'h00, start_q, 2'h0};
            IDX_MAIN_CONTROL_B: rd_byte = {3'h0, signedness_select_q, 1'b0, fmt_q, cmp_mode_q};
            default: rd_byte = BYTE_ZERO;
        endcase
    end

    // Read data register; unmapped indices answer zero with an error.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, rd_byte};
            s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Plain configuration registers; reserved bits are dropped on write.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            input_kind_q <= 2'h0;
            divider_code_q <= 3'h0;
            sample_length_value_q <= 6'h00;
            trim_q <= 12'h000;
            cmp_mode_q <= 1'b0;
            fmt_q <= FMT_RIGHT12;
            signedness_select_q <= 1'b0;
        end else if (wr_en) begin
            unique case (wr_idx)
                IDX_CHANNEL_CONTROL: input_kind_q <= wr_byte[1:0];
                IDX_CLOCK_DIVIDER: divider_code_q <= wr_byte[2:0];
                IDX_SAMPLE_LENGTH: sample_length_value_q <= wr_byte[5:0];
                IDX_TRIM_LOW: trim_q[7:0] <= wr_byte;
                IDX_TRIM_HIGH: trim_q[11:8] <= wr_byte[3:0];
                IDX_MAIN_CONTROL_B: begin
                    cmp_mode_q <= wr_byte[CMP_MODE_BIT];
                    fmt_q <= result_format_e'(wr_byte[FMT_LSB +: 2]);
                    signedness_select_q <= wr_byte[SIGNED_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    // Byte latch: direct writes, low threshold writes, and copies on low reads.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            byte_latch_q <= BYTE_ZERO;
        end else if (rd_fire && rd_idx == IDX_RESULT_LOW) begin
            byte_latch_q <= conversion_result_q[15:8];
        end else if (rd_fire && rd_idx == IDX_THRESHOLD_LOW) begin
            byte_latch_q <= threshold_value_q[15:8];
        end else if (rd_fire && rd_idx == IDX_TRIM_LOW) begin
            byte_latch_q <= {4'h0, trim_q[11:8]};
        end else if (wr_en && (wr_idx == IDX_BYTE_LATCH || wr_idx == IDX_THRESHOLD_LOW)) begin
            byte_latch_q <= wr_byte;
        end
    end

    // Threshold commits both bytes when the high byte is written.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            threshold_value_q <= WORD_ZERO;
        end else if (wr_en && wr_idx == IDX_THRESHOLD_HIGH) begin
            threshold_value_q <= {wr_byte, byte_latch_q};
        end
    end

    // Start bit: set by a write of one through either alias, cleared on start.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_q <= 1'b0;
        end else if (start_q && state_q == ST_IDLE) begin
            start_q <= 1'b0;
        end else if (wr_en && !start_q && state_q == ST_IDLE
                && ((wr_idx == IDX_CHANNEL_CONTROL && wr_byte[START_BIT])
                || (wr_idx == IDX_MAIN_CONTROL_A && wr_byte[ALIAS_START_BIT]))) begin
            start_q <= 1'b1;
        end
    end

    // Prescaler; restarted when sampling begins so the phase is aligned.
    assign half_tick = div_cnt_q >= half_period(divider_code_q) - 9'h001;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt_q <= 9'h000;
            conv_clk_q <= 1'b0;
        end else if (state_q == ST_IDLE && start_q) begin
            div_cnt_q <= 9'h000;
            conv_clk_q <= 1'b0;
        end else if (half_tick) begin
            div_cnt_q <= 9'h000;
            conv_clk_q <= !conv_clk_q;
        end else begin
            div_cnt_q <= div_cnt_q + 9'h001;
        end
    end

    // Sequencer: idle, sample for the set length, then wait for the core.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ST_IDLE;
            half_cnt_q <= 6'h00;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    half_cnt_q <= 6'h00;
                    if (start_q) begin
                        state_q <= ST_SAMPLE;
                    end
                end
                ST_SAMPLE: begin
                    if (half_tick) begin
                        half_cnt_q <= half_cnt_q + 6'h01;
                        if (half_cnt_q == sample_length_value_q) begin
                            state_q <= ST_CONVERT;
                        end
                    end
                end
                ST_CONVERT: begin
                    if (core_ret.done) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Commands to the core.
    always_comb begin
        core_cmd.conv_clk = conv_clk_q;
        core_cmd.sampling = state_q == ST_SAMPLE;
        core_cmd.convert_go = state_q == ST_SAMPLE && half_tick
            && half_cnt_q == sample_length_value_q;
        core_cmd.trim = trim_q;
    end

    // Formatting and compare of the finishing conversion.
    assign new_result = format_result(core_ret.raw, fmt_q, signedness_select_q,
        signedness_select_q & input_kind_q[1]);
    assign cmp_hit = signedness_select_q
        ? ($signed(new_result) > $signed(threshold_value_q))
        : (new_result > threshold_value_q);
    assign done_event = state_q == ST_CONVERT && core_ret.done
        && (!cmp_mode_q || cmp_hit);

    // Result pair updates on every finished conversion.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conversion_result_q <= WORD_ZERO;
        end else if (state_q == ST_CONVERT && core_ret.done) begin
            conversion_result_q <= new_result;
        end
    end

    // Completion flag; a set in the same cycle as a clear wins.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            channel_done_flag_q <= 1'b0;
        end else if (done_event) begin
            channel_done_flag_q <= 1'b1;
        end else if (vector_taken) begin
            channel_done_flag_q <= 1'b0;
        end else if (wr_en && wr_idx == IDX_COMPLETION_FLAGS && wr_byte[DONE_BIT]) begin
            channel_done_flag_q <= 1'b0;
        end
    end

    // Assertions.
    property p_flag_set;
        @(posedge aclk) disable iff (!aresetn) done_event |=> channel_done_flag_q;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set");
    property p_cmp_gate;
        @(posedge aclk) disable iff (!aresetn)
            (!channel_done_flag_q && cmp_mode_q && core_ret.done && !cmp_hit
            && !$rose(channel_done_flag_q)) |=> !channel_done_flag_q;
    endproperty
    a_cmp_gate: assert property (p_cmp_gate) else $error("flag set without match");
    property p_vec_clear;
        @(posedge aclk) disable iff (!aresetn) (vector_taken && !done_event) |=> !channel_done_flag_q;
    endproperty
    a_vec_clear: assert property (p_vec_clear) else $error("vector did not clear");
    property p_w1c;
        @(posedge aclk) disable iff (!aresetn)
            (wr_en && wr_idx == IDX_COMPLETION_FLAGS && !wr_byte[DONE_BIT]
            && !vector_taken && channel_done_flag_q) |=> channel_done_flag_q;
    endproperty
    a_w1c: assert property (p_w1c) else $error("zero write cleared flag");
    property p_latch_copy;
        @(posedge aclk) disable iff (!aresetn)
            (rd_fire && rd_idx == IDX_RESULT_LOW) |=> byte_latch_q == $past(conversion_result_q[15:8]);
    endproperty
    a_latch_copy: assert property (p_latch_copy) else $error("latch copy wrong");
    property p_sample_len;
        @(posedge aclk) disable iff (!aresetn)
            $rose(core_cmd.sampling) |-> core_cmd.sampling throughout
            (##1 (half_cnt_q <= sample_length_value_q));
    endproperty
    a_sample_len: assert property (p_sample_len) else $error("sampling ended early");
    property p_start_clear;
        @(posedge aclk) disable iff (!aresetn) $rose(start_q) |-> ##1 !start_q ##0 core_cmd.sampling;
    endproperty
    a_start_clear: assert property (p_start_clear) else $error("start not cleared");
    property p_left_fmt;
        @(posedge aclk) disable iff (!aresetn)
            (state_q == ST_CONVERT && core_ret.done && fmt_q == FMT_LEFT12)
            |=> conversion_result_q == {$past(core_ret.raw), 4'h0};
    endproperty
    a_left_fmt: assert property (p_left_fmt) else $error("left format wrong");
    property p_thr_commit;
        @(posedge aclk) disable iff (!aresetn)
            (wr_en && wr_idx == IDX_THRESHOLD_HIGH) |=> threshold_value_q[15:8] == $past(wr_byte);
    endproperty
    a_thr_commit: assert property (p_thr_commit) else $error("threshold not committed");
    c_conv: cover property (@(posedge aclk) disable iff (!aresetn) done_event);
    c_set_clear: cover property (@(posedge aclk) disable iff (!aresetn) done_event && vector_taken);
    c_latch_rd: cover property (@(posedge aclk) disable iff (!aresetn)
        rd_fire && rd_idx == IDX_RESULT_HIGH);
endmodule // adc_control_result_regs
`default_nettype wire

// [test/core_model.sv]
/* Stand-in for the converter core behind the control block.
   Assumes the block's command struct and a single clock. */
`default_nettype none
module core_model
    import adc_ctrl_pkg::*;
(
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Command in, raw value to hand back, answer out.
    input wire core_cmd_s cmd,
    input wire logic [11:0] value,
    output core_ret_s ret
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_q; // Cycles left until the done pulse.
    // A conversion takes five cycles after convert_go.
    always_ff @(posedge aclk) begin
        if (!aresetn) wait_q <= 4'h0;
        else if (cmd.convert_go) wait_q <= 4'h5;
        else if (wait_q != 4'h0) wait_q <= wait_q - 4'h1;
    end
    // Outside the done cycle the raw lines show the inverse, never the value.
    assign ret.done = (wait_q == 4'h1);
    assign ret.raw = ret.done ? value : ~value;
endmodule // core_model
`default_nettype wire

// [test/test_adc_control_result_regs.sv]
/* Bench for the converter control block: registers, pairs, formats, flag.
   Assumes the core_model stand-in and AXI4-Lite on one clock. */
`default_nettype none
module test_adc_control_result_regs
    import adc_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, arv = 1'b0, vec = 1'b0;
    logic awr, wrr, bv, arr, rv;
    logic [1:0] bresp, rresp, rsp;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h00000000, rdata, rdat;
    logic [11:0] raw_v = 12'h000;
    core_cmd_s cmd;
    core_ret_s ret;
    int fail_count = 0, samples_checked = 0, s_cnt = 0;
    adc_control_result_regs dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wv), .s_axi_wready(wrr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(1'b1),
        .core_cmd(cmd), .core_ret(ret), .vector_taken(vec));
    core_model partner (.aclk(aclk), .aresetn(aresetn), .cmd(cmd), .value(raw_v), .ret(ret));
    initial forever #2 aclk = ~aclk;
    // Counts cycles of the sampling phase.
    always @(posedge aclk) if (cmd.sampling) s_cnt <= s_cnt + 1;
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        samples_checked++;
        if (s !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    // Write: both channels offered, each released at its own handshake.
    task automatic wr(input logic [5:0] i, input logic [7:0] d);
        logic ta = 1'b0, tw = 1'b0;
        awa <= {i, 2'b00};
        wd <= {24'h000000, d};
        awv <= 1'b1;
        wv <= 1'b1;
        do begin
            @(negedge aclk);
            ta = ta | (awv & awr);
            tw = tw | (wv & wrr);
            @(posedge aclk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
        end while (!(ta && tw));
        do begin
            @(negedge aclk);
            ta = bv;
            rsp = bresp;
            @(posedge aclk);
        end while (!ta);
    endtask
    task automatic rd(input logic [5:0] i);
        logic t;
        ara <= {i, 2'b00};
        arv <= 1'b1;
        do begin
            @(negedge aclk);
            t = arr;
            @(posedge aclk);
        end while (!t);
        arv <= 1'b0;
        do begin
            @(negedge aclk);
            t = rv;
            rdat = rdata;
            rsp = rresp;
            @(posedge aclk);
        end while (!t);
    endtask
    task automatic rc(input string n, input logic [5:0] i, input logic [7:0] e);
        rd(i);
        chk(n, {24'h000000, e}, rdat);
    endtask
    // Reset values, read-write, unmapped place.
    task automatic t_regs;
        int n;
        rc("divider rst", IDX_CLOCK_DIVIDER, 8'h00);
        rc("flags rst", IDX_COMPLETION_FLAGS, 8'h00);
        wr(IDX_CLOCK_DIVIDER, 8'h01);
        chk("write resp", 32'(RESP_OKAY), 32'(rsp));
        rc("divider", IDX_CLOCK_DIVIDER, 8'h01);
        chk("read resp", 32'(RESP_OKAY), 32'(rsp));
        // One prescaled period, from a first high cycle to the next; code 1 divides by 8.
        do @(posedge aclk); while (cmd.conv_clk !== 1'b0);
        do @(posedge aclk); while (cmd.conv_clk !== 1'b1);
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (cmd.conv_clk !== 1'b0);
        do begin
            @(posedge aclk);
            n++;
        end while (cmd.conv_clk !== 1'b1);
        chk("conv clk period", 32'h00000008, 32'(n));
        rd(6'h3F);
        chk("unmapped", 32'(RESP_SLVERR), 32'(rsp));
        chk("unmapped data", 32'h00000000, rdat);
        wr(6'h3F, 8'h00);
        chk("unmapped wr", 32'(RESP_SLVERR), 32'(rsp));
    endtask
    // Byte latch, threshold pair and trim store.
    task automatic t_pairs;
        wr(IDX_BYTE_LATCH, 8'h5A);
        rc("latch", IDX_BYTE_LATCH, 8'h5A);
        wr(IDX_THRESHOLD_LOW, 8'h34);
        wr(IDX_THRESHOLD_HIGH, 8'h12);
        rc("thr low", IDX_THRESHOLD_LOW, 8'h34);
        rc("thr high", IDX_THRESHOLD_HIGH, 8'h12);
        wr(IDX_THRESHOLD_LOW, 8'h56);
        rc("thr kept", IDX_THRESHOLD_LOW, 8'h34);
        wr(IDX_TRIM_LOW, 8'hAB);
        wr(IDX_TRIM_HIGH, 8'h0C);
        chk("trim", 32'h00000CAB, 32'(cmd.trim));
    endtask
    // One conversion: format, start path, result, flag and its clearing.
    task automatic conv(input logic [7:0] mb, cc, input logic al, vc,
            input logic [15:0] e, input logic f);
        int s0;
        raw_v <= 12'h9A5;
        s0 = s_cnt;
        wr(IDX_MAIN_CONTROL_B, mb);
        wr(IDX_CHANNEL_CONTROL, al ? cc : (cc | 8'h80));
        if (al) wr(IDX_MAIN_CONTROL_A, 8'h04);
        do @(negedge aclk); while (ret.done !== 1'b1);
        @(posedge aclk);
        chk("sample cycles", 32'h00000004, 32'(s_cnt - s0));
        rc("flag", IDX_COMPLETION_FLAGS, {7'h00, f});
        rc("res low", IDX_RESULT_LOW, e[7:0]);
        rc("res high", IDX_RESULT_HIGH, e[15:8]);
        rc("start", IDX_CHANNEL_CONTROL, cc);
        if (vc) begin
            vec <= 1'b1;
            @(posedge aclk);
            vec <= 1'b0;
        end else begin
            wr(IDX_COMPLETION_FLAGS, 8'h00);
            rc("flag kept", IDX_COMPLETION_FLAGS, {7'h00, f});
            wr(IDX_COMPLETION_FLAGS, 8'h01);
        end
        rc("flag clr", IDX_COMPLETION_FLAGS, 8'h00);
    endtask
    task automatic report_and_stop;
        $display("checked %0d failed %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        report_and_stop;
    end
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs;
        t_pairs;
        conv(8'h00, 8'h01, 1'b0, 1'b0, 16'h09A5, 1'b1);
        conv(8'h10, 8'h02, 1'b1, 1'b1, 16'hF9A5, 1'b1);
        conv(8'h06, 8'h01, 1'b0, 1'b1, 16'h9A50, 1'b1);
        conv(8'h14, 8'h01, 1'b0, 1'b1, 16'hFFA5, 1'b1);
        conv(8'h04, 8'h01, 1'b0, 1'b1, 16'h00A5, 1'b1);
        conv(8'h02, 8'h01, 1'b0, 1'b1, 16'h09A5, 1'b1);
        conv(8'h01, 8'h01, 1'b0, 1'b1, 16'h09A5, 1'b0);
        conv(8'h11, 8'h02, 1'b0, 1'b1, 16'hF9A5, 1'b0);
        conv(8'h07, 8'h01, 1'b0, 1'b0, 16'h9A50, 1'b1);
        report_and_stop;
    end
endmodule // test_adc_control_result_regs
`default_nettype wire
